/* verilog/sms_send_request_sequencer.sv */
// per-instance send sequencer sharing one modem attempt port
`timescale 1ns/1ns
module sms_send_request_sequencer #(
  parameter int N = 4,
  parameter int IW = 2,
  parameter longint unsigned RETRY_GAP = sms_pkg::RETRY_GAP_CYC,
  parameter int unsigned SCAN_CYC = 1
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic [N-1:0] request_i,
  input wire logic [N-1:0] dest_is_email_i,
  input wire logic [N-1:0] param_ok_i,
  input wire logic mobile_centre_set_i,
  input wire logic gateway_centre_set_i,
  input wire logic modem_ready_i,
  input wire logic remote_access_i,
  input wire logic modem_res_valid_i,
  input wire logic modem_res_ok_i,
  output logic modem_req_valid_o,
  output logic [IW-1:0] modem_req_inst_o,
  output logic modem_req_gateway_o,
  output logic [N-1:0] done_o,
  output logic [N*16-1:0] status_o
);
  localparam int GW = 40;
  localparam logic [GW-1:0] GAP = GW'(RETRY_GAP);
  localparam logic [1:0] MAX_TRY = 2'(sms_pkg::RETRIES);

  logic rs1_r, rst_n;
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rs1_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rs1_r <= 1'b1;
      rst_n <= rs1_r;
    end
  end

  // external levels come in over four flops
  logic [N+1:0] ext_s;
  sms_sync #(.W(N + 2)) u_sync (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n),
    .d_i({remote_access_i, modem_ready_i, request_i}),
    .q_o(ext_s)
  );
  logic [N-1:0] req;
  logic ready_s, remote_s;
  assign req = ext_s[N-1:0];
  assign ready_s = ext_s[N];
  assign remote_s = ext_s[N+1];

  sms_pkg::seq_state_t st_r [N];
  sms_pkg::seq_state_t st_nxt [N];
  logic [N-1:0] req_d_r, dropped_r, done_r, failed_r, perr_r;
  logic [N-1:0] dropped_nxt, done_nxt, failed_nxt, perr_nxt, push;
  logic [15:0] stat_r [N];
  logic [15:0] stat_nxt [N];
  // scan counter: output lingers SCAN_CYC cycles after a drop
  localparam int SCW = 16;
  localparam logic [SCW-1:0] SCAN_LAST = SCW'(SCAN_CYC - 1);
  logic [SCW-1:0] scan_r [N];
  logic [SCW-1:0] scan_nxt [N];

  // shared modem channel state
  logic act_r, act_nxt;
  logic [IW-1:0] owner_r, owner_nxt;
  logic [1:0] tries_r, tries_nxt;
  logic [GW-1:0] gap_r, gap_nxt;
  logic inflight_r, inflight_nxt;
  logic mreq_r, mreq_nxt, mgw_r, mgw_nxt;
  logic pop;
  logic head_v;
  logic [IW-1:0] head;
  logic fin_ok, fin_fail;

  sms_fifo_arb #(.N(N), .IW(IW)) u_arb (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n),
    .push_i(push),
    .pop_i(pop),
    .head_valid_o(head_v),
    .head_o(head)
  );

  function automatic logic pick_gateway(input logic email,
      input logic mob_set, input logic gw_set);
    pick_gateway = email ? gw_set : !mob_set;
  endfunction : pick_gateway

  always_comb begin
    act_nxt = act_r;
    owner_nxt = owner_r;
    tries_nxt = tries_r;
    gap_nxt = gap_r;
    inflight_nxt = inflight_r;
    mreq_nxt = 1'b0;
    mgw_nxt = mgw_r;
    pop = 1'b0;
    fin_ok = 1'b0;
    fin_fail = 1'b0;
    if (!act_r) begin
      if (head_v && ready_s && !remote_s) begin
        act_nxt = 1'b1;
        owner_nxt = head;
        tries_nxt = '0;
        gap_nxt = '0;
        pop = 1'b1;
      end
    end else if (inflight_r) begin
      if (modem_res_valid_i) begin
        inflight_nxt = 1'b0;
        if (modem_res_ok_i) begin
          fin_ok = 1'b1;
          act_nxt = 1'b0;
        end else if (tries_r == MAX_TRY) begin
          fin_fail = 1'b1;
          act_nxt = 1'b0;
        end else begin
          tries_nxt = tries_r + 2'd1;
          gap_nxt = GAP;
        end
      end
    end else if (gap_r != '0) begin
      gap_nxt = gap_r - GW'(1);
    end else if (!remote_s) begin
      mreq_nxt = 1'b1;
      inflight_nxt = 1'b1;
      mgw_nxt = pick_gateway(dest_is_email_i[owner_r],
        mobile_centre_set_i, gateway_centre_set_i);
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      act_r <= 1'b0;
      owner_r <= '0;
      tries_r <= '0;
      gap_r <= '0;
      inflight_r <= 1'b0;
      mreq_r <= 1'b0;
      mgw_r <= 1'b0;
    end else begin
      act_r <= act_nxt;
      owner_r <= owner_nxt;
      tries_r <= tries_nxt;
      gap_r <= gap_nxt;
      inflight_r <= inflight_nxt;
      mreq_r <= mreq_nxt;
      mgw_r <= mgw_nxt;
    end
  end

  generate
    for (genvar i = 0; i < N; i++) begin : g_inst
      logic mine;
      logic [15:0] sv;
      assign mine = act_r && (owner_r == IW'(i));
      always_comb begin
        st_nxt[i] = st_r[i];
        dropped_nxt[i] = dropped_r[i];
        done_nxt[i] = done_r[i];
        failed_nxt[i] = failed_r[i];
        perr_nxt[i] = perr_r[i];
        push[i] = 1'b0;
        scan_nxt[i] = scan_r[i];
        unique case (st_r[i])
          sms_pkg::S_IDLE: begin
            if (req[i] && !req_d_r[i]) begin
              dropped_nxt[i] = 1'b0;
              failed_nxt[i] = 1'b0;
              if (!param_ok_i[i]) begin
                perr_nxt[i] = 1'b1;
                done_nxt[i] = 1'b1;
                st_nxt[i] = sms_pkg::S_HOLD;
              end else begin
                push[i] = 1'b1;
                st_nxt[i] = sms_pkg::S_WAIT;
              end
            end
          end
          sms_pkg::S_WAIT: begin
            if (mine) st_nxt[i] = sms_pkg::S_SEND;
          end
          sms_pkg::S_SEND: begin
            if (fin_ok || fin_fail) begin
              done_nxt[i] = 1'b1;
              failed_nxt[i] = fin_fail;
              st_nxt[i] = sms_pkg::S_HOLD;
            end
          end
          sms_pkg::S_HOLD: begin
            if (dropped_r[i] || !req[i]) begin
              st_nxt[i] = sms_pkg::S_SCAN;
              scan_nxt[i] = SCAN_LAST;
            end
          end
          sms_pkg::S_SCAN: begin
            // output stays on for the whole scan
            if (scan_r[i] != '0) begin
              scan_nxt[i] = scan_r[i] - SCW'(1);
            end else begin
              done_nxt[i] = 1'b0;
              perr_nxt[i] = 1'b0;
              failed_nxt[i] = 1'b0;
              st_nxt[i] = sms_pkg::S_IDLE;
            end
          end
          default: st_nxt[i] = sms_pkg::S_IDLE;
        endcase
        if (st_r[i] != sms_pkg::S_IDLE && !req[i]) dropped_nxt[i] = 1'b1;
        if (st_r[i] == sms_pkg::S_SCAN) dropped_nxt[i] = 1'b0;
        sv = sms_pkg::STATUS_ZERO;
        sv[sms_pkg::ST_DONE] = done_nxt[i] && !failed_nxt[i]
          && !perr_nxt[i];
        sv[sms_pkg::ST_BUSY] = (st_nxt[i] == sms_pkg::S_SEND);
        sv[sms_pkg::ST_WAIT] = (st_nxt[i] == sms_pkg::S_WAIT);
        sv[sms_pkg::ST_FAIL] = failed_nxt[i];
        sv[sms_pkg::ST_PERR] = perr_nxt[i];
        stat_nxt[i] = done_nxt[i] || st_nxt[i] == sms_pkg::S_WAIT
          || st_nxt[i] == sms_pkg::S_SEND ? sv : sms_pkg::STATUS_ZERO;
      end

      always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
          st_r[i] <= sms_pkg::S_IDLE;
          req_d_r[i] <= 1'b0;
          dropped_r[i] <= 1'b0;
          done_r[i] <= 1'b0;
          failed_r[i] <= 1'b0;
          perr_r[i] <= 1'b0;
          stat_r[i] <= sms_pkg::STATUS_ZERO;
          scan_r[i] <= '0;
        end else begin
          st_r[i] <= st_nxt[i];
          req_d_r[i] <= req[i];
          dropped_r[i] <= dropped_nxt[i];
          done_r[i] <= done_nxt[i];
          failed_r[i] <= failed_nxt[i];
          perr_r[i] <= perr_nxt[i];
          stat_r[i] <= stat_nxt[i];
          scan_r[i] <= scan_nxt[i];
        end
      end
      assign status_o[i*16 +: 16] = stat_r[i];

      upper_zero_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
        stat_r[i][15:5] == 11'h000) else $error("status upper bits set");
      word_clear_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
        $fell(done_r[i]) |-> stat_r[i] == sms_pkg::STATUS_ZERO)
        else $error("status not cleared");
      ignore_busy_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
        st_r[i] != sms_pkg::S_IDLE |-> !push[i])
        else $error("request taken while busy");
      scan_pulse_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (st_r[i] == sms_pkg::S_SCAN && scan_r[i] == '0) |=> !done_r[i])
        else $error("output held past scan");
      hold_out_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (st_r[i] == sms_pkg::S_HOLD && req[i] && !dropped_r[i])
        |=> done_r[i]) else $error("output dropped early");
      busy_bit_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (st_r[i] == sms_pkg::S_SEND) |-> stat_r[i][sms_pkg::ST_BUSY])
        else $error("busy bit missing");
      wait_bit_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (st_r[i] == sms_pkg::S_WAIT) |-> stat_r[i][sms_pkg::ST_WAIT])
        else $error("wait bit missing");
      fail_mark_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (st_r[i] == sms_pkg::S_SEND && fin_fail)
        |=> done_r[i] && failed_r[i]) else $error("failure not flagged");
    end
  endgenerate

  assign done_o = done_r;
  assign modem_req_valid_o = mreq_r;
  assign modem_req_inst_o = owner_r;
  assign modem_req_gateway_o = mgw_r;

  // failed answer to the attempt in flight
  sequence failed_try_s;
    inflight_r && modem_res_valid_i && !modem_res_ok_i;
  endsequence
  // give up after the last retry
  retry_max_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
    failed_try_s ##0 (tries_r == MAX_TRY) |=> !act_r && !mreq_r)
    else $error("too many retries");
  retry_gap_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
    failed_try_s ##0 (tries_r != MAX_TRY) |=> !mreq_r ##1 !mreq_r)
    else $error("retry sent without pause");
  remote_inhibit_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
    $rose(mreq_r) |-> !$past(remote_s)) else $error("sent under remote");
  sequence attempt_s;
    mreq_r ##1 inflight_r;
  endsequence
  one_flight_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
    attempt_s |-> !mreq_r) else $error("second attempt in flight");
  unable_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
    (!act_r && (!ready_s || remote_s)) |=> !act_r)
    else $error("owner taken while unable");
endmodule : sms_send_request_sequencer

/* verilog/sms_pkg.sv */
// shared types and constants for the short-message send sequencer
package sms_pkg;
  localparam int unsigned CLK_MHZ = 250;
  // retry window in milliseconds, as printed: two minutes
  localparam longint unsigned RETRY_WINDOW_MS = 120000;
  localparam int unsigned RETRIES = 3;
  // spacing between attempts spreads the retries over the window
  localparam longint unsigned RETRY_GAP_CYC =
    (RETRY_WINDOW_MS * 1000 * CLK_MHZ) / RETRIES;
  localparam int unsigned ST_DONE = 0;
  localparam int unsigned ST_BUSY = 1;
  localparam int unsigned ST_WAIT = 2;
  localparam int unsigned ST_FAIL = 3;
  localparam int unsigned ST_PERR = 4;
  localparam logic [15:0] STATUS_ZERO = 16'h0000;
  localparam logic [1:0] DEST_MOBILE = 2'h0;
  localparam logic [1:0] DEST_GATEWAY = 2'h1;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_WAIT = 3'b001,
    S_SEND = 3'b010,
    S_GAP = 3'b011,
    S_HOLD = 3'b100,
    S_SCAN = 3'b101
  } seq_state_t;

  // one attempt towards the modem
  typedef struct packed {
    logic valid;
    logic [1:0] inst;
    logic use_gateway;
  } modem_req_t;

  typedef struct packed {
    logic valid;
    logic ok;
  } modem_res_t;
endpackage : sms_pkg

/* verilog/sms_fifo_arb.sv */
// first-come queue of pending instance indices
`timescale 1ns/1ns
module sms_fifo_arb #(
  parameter int N = 4,
  parameter int IW = 2
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [N-1:0] push_i,
  input wire logic pop_i,
  output logic head_valid_o,
  output logic [IW-1:0] head_o
);
  logic [IW-1:0] q_r [N];
  logic [IW-1:0] q_nxt [N];
  logic [IW:0] cnt_r;
  logic [IW:0] cnt_nxt;

  always_comb begin
    int c;
    c = int'(cnt_r);
    q_nxt = q_r;
    if (pop_i && c > 0) begin
      for (int k = 0; k < N - 1; k++) begin
        q_nxt[k] = q_r[k + 1];
      end
      c = c - 1;
    end
    for (int k = 0; k < N; k++) begin
      if (push_i[k] && c < N) begin
        q_nxt[c] = IW'(k);
        c = c + 1;
      end
    end
    cnt_nxt = (IW + 1)'(c);
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= '0;
      for (int k = 0; k < N; k++) begin
        q_r[k] <= '0;
      end
    end else begin
      cnt_r <= cnt_nxt;
      q_r <= q_nxt;
    end
  end

  assign head_valid_o = (cnt_r != '0);
  assign head_o = q_r[0];
endmodule : sms_fifo_arb

/* verilog/sms_sync.sv */
// four-flop input synchroniser with agreement check
`timescale 1ns/1ns
module sms_sync #(
  parameter int W = 1
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] s1_r, s2_r, s3_r, q_r;
  logic [W-1:0] q_nxt;

  always_comb begin
    for (int k = 0; k < W; k++) begin
      q_nxt[k] = (s2_r[k] == s3_r[k]) ? s2_r[k] : q_r[k];
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      q_r <= '0;
    end else begin
      s1_r <= d_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_r <= q_nxt;
    end
  end

  assign q_o = q_r;
endmodule : sms_sync

/* tb/sms_modem_model.sv */
// modem stand-in: answers each attempt after a set latency
`timescale 1ns/1ns
module sms_modem_model (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic req_valid_i,
  input wire logic fail_i,
  input wire logic [7:0] lat_i,
  output logic res_valid_o,
  output logic res_ok_o
);
  int cnt;
  always @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt <= 0;
      res_valid_o <= 1'b0;
      res_ok_o <= 1'b0;
    end else begin
      res_valid_o <= 1'b0;
      // result line carries no meaning between answers
      res_ok_o <= ~res_ok_o;
      if (req_valid_i) begin
        cnt <= int'(lat_i) + 1;
      end else if (cnt == 1) begin
        res_valid_o <= 1'b1;
        res_ok_o <= ~fail_i;
        cnt <= 0;
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule : sms_modem_model

/* tb/sms_send_request_sequencer_tb_top.sv */
// self-checking bench for the send sequencer
`timescale 1ns/1ns
module sms_send_request_sequencer_tb_top;
  localparam int GAP = 20;
  localparam int SCAN = 1;
  logic mclk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [3:0] request_i = 4'h0;
  logic [3:0] email = 4'h0;
  logic [3:0] param_ok = 4'hf;
  logic mob_set = 1'b1;
  logic gw_set = 1'b1;
  logic ready = 1'b1;
  logic remote = 1'b0;
  logic fail = 1'b0;
  logic [7:0] lat = 8'h02;
  logic res_valid;
  logic res_ok;
  logic req_valid;
  logic req_gw;
  logic [1:0] req_inst;
  logic [3:0] done_o;
  logic [63:0] status_o;
  int err_count = 0;
  int num_checks = 0;
  int inst_q[$];
  logic gw_q[$];
  longint t_q[$];
  longint cyc = 0;
  // service order of the contention scenario
  int fifo_ord[3] = '{2, 0, 3};

  always #2 mclk_i = ~mclk_i;

  sms_send_request_sequencer #(.N(4), .IW(2), .RETRY_GAP(GAP),
    .SCAN_CYC(SCAN)) uut (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .request_i(request_i),
    .dest_is_email_i(email), .param_ok_i(param_ok),
    .mobile_centre_set_i(mob_set), .gateway_centre_set_i(gw_set),
    .modem_ready_i(ready), .remote_access_i(remote),
    .modem_res_valid_i(res_valid), .modem_res_ok_i(res_ok),
    .modem_req_valid_o(req_valid), .modem_req_inst_o(req_inst),
    .modem_req_gateway_o(req_gw), .done_o(done_o), .status_o(status_o)
  );

  sms_modem_model modem (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .req_valid_i(req_valid),
    .fail_i(fail), .lat_i(lat), .res_valid_o(res_valid),
    .res_ok_o(res_ok)
  );

  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (req_valid === 1'b1) begin
      inst_q.push_back(int'(req_inst));
      gw_q.push_back(req_gw);
      t_q.push_back(cyc);
    end
  end

  function automatic logic exp_gw(input logic em, input logic mob,
    input logic gw);
    return (em & gw) | ~mob;
  endfunction : exp_gw

  task automatic chk(input string what, input logic [15:0] seen,
    input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : tick

  task automatic sbit(input string what, input int i, input int b);
    chk(what, {15'h0, status_o[16*i+b]}, 16'h0001);
  endtask : sbit

  task automatic req(input int i, input int hold);
    inst_q.delete();
    gw_q.delete();
    t_q.delete();
    @(posedge mclk_i);
    request_i[i] <= 1'b1;
    if (hold > 0) begin
      tick(hold);
      @(posedge mclk_i);
      request_i[i] <= 1'b0;
    end
  endtask : req

  task automatic wait_done(input int i);
    int k;
    k = 0;
    while (done_o[i] !== 1'b1 && k < 3000) begin
      tick(1);
      k++;
    end
    chk("done", {15'h0, done_o[i]}, 16'h0001);
    chk("upper", {5'h0, status_o[16*i+5 +: 11]}, 16'h0000);
  endtask : wait_done

  task automatic drop(input int i);
    @(posedge mclk_i);
    request_i[i] <= 1'b0;
    tick(8);
    chk("done off", {15'h0, done_o[i]}, 16'h0000);
    chk("word off", status_o[16*i +: 16], 16'h0000);
  endtask : drop

  task automatic summarize();
    if (err_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize

  initial begin
    #120000;
    err_count++;
    summarize();
  end

  initial begin
    int i;
    int n;
    logic g;
    void'($urandom(2203));
    tick(2);
    resetn_i <= 1'b1;
    tick(10);
    req(0, 0);
    wait_done(0);
    sbit("complete", 0, 0);
    tick(6);
    chk("held done", {15'h0, done_o[0]}, 16'h0001);
    chk("one try", 16'(inst_q.size()), 16'h0001);
    drop(0);
    lat <= 8'h28;
    req(1, 8);
    // second rise while the send is under way
    tick(2);
    @(posedge mclk_i);
    request_i[1] <= 1'b1;
    tick(8);
    @(posedge mclk_i);
    request_i[1] <= 1'b0;
    wait_done(1);
    n = 0;
    while (done_o[1] === 1'b1 && n < 10) begin
      tick(1);
      n++;
    end
    // completion cycle plus one scan
    chk("one scan", 16'(n), 16'(1 + SCAN));
    tick(6);
    chk("ignored rise", 16'(inst_q.size()), 16'h0001);
    fail <= 1'b1;
    lat <= 8'($urandom_range(1, 8));
    req(2, 0);
    wait_done(2);
    sbit("failed", 2, 3);
    chk("attempts", 16'(inst_q.size()), 16'h0004);
    for (int k = 1; k < t_q.size(); k++) begin
      chk("gap", 16'(t_q[k] - t_q[k-1] >= GAP), 16'h0001);
    end
    drop(2);
    fail <= 1'b0;
    param_ok[3] <= 1'b0;
    req(3, 0);
    wait_done(3);
    sbit("param err", 3, 4);
    chk("no try", 16'(inst_q.size()), 16'h0000);
    drop(3);
    param_ok[3] <= 1'b1;
    for (int c = 2; c < 8; c++) begin
      i = int'($urandom_range(0, 3));
      email[i] <= c[0];
      mob_set <= c[1];
      gw_set <= c[2];
      req(i, 0);
      wait_done(i);
      g = exp_gw(c[0], c[1], c[2]);
      chk("centre", {15'h0, gw_q[0]}, {15'h0, g});
      drop(i);
    end
    lat <= 8'h1e;
    req(2, 0);
    tick(3);
    @(posedge mclk_i);
    request_i[0] <= 1'b1;
    tick(3);
    @(posedge mclk_i);
    request_i[3] <= 1'b1;
    tick(12);
    sbit("waiting", 0, 2);
    wait_done(3);
    chk("fifo n", 16'(inst_q.size()), 16'h0003);
    for (int k = 0; k < 3; k++) begin
      chk("fifo", 16'(inst_q[k]), 16'(fifo_ord[k]));
    end
    drop(2);
    drop(0);
    drop(3);
    for (int b = 0; b < 2; b++) begin
      remote <= b[0];
      // modem not ready first, then remote access
      ready <= b[0];
      req(1, 0);
      tick(40);
      chk("blocked", 16'(inst_q.size()), 16'h0000);
      sbit("blocked wait", 1, 2);
      remote <= 1'b0;
      ready <= 1'b1;
      wait_done(1);
      chk("released", 16'(inst_q.size()), 16'h0001);
      drop(1);
    end
    summarize();
  end
endmodule : sms_send_request_sequencer_tb_top
